// ### include/hfilt_pkg.sv
/*
 * Shared constants for the two-dimensional image filter core: widths,
 * configuration bit positions, coefficient store shape and line buffer limits.
 * Assumes it is compiled before every design file that names it.
 */
package hfilt_pkg;

  // ----------------------------------------------------------------------
  // Clock and data widths
  // ----------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MAX_RATE_MHZ = 111;
  localparam int CLK_RATE_MHZ = 1000 / CLK_PERIOD_NS;
  localparam int DATA_W = 12;
  localparam int COEF_W = 12;
  localparam int PRE_W = DATA_W + 1;
  localparam int PROD_W = PRE_W + COEF_W;
  localparam int ACC_W = 32;
  localparam int OUT_LSB = 11;

  // ----------------------------------------------------------------------
  // Horizontal filter shape
  // ----------------------------------------------------------------------
  localparam int H_ALUS = 8;
  localparam int ID_MAX = 16;
  localparam int LEN_W = 4;
  localparam int ALU_MODE_BIT = 0;
  localparam int PASS_A_BIT = 1;
  localparam int PASS_B_BIT = 2;
  localparam int ID_LEN_LSB = 1;
  localparam int ID_LEN_MSB = 4;

  // ----------------------------------------------------------------------
  // Coefficient store and vertical filter
  // ----------------------------------------------------------------------
  localparam int SETS = 256;
  localparam int SET_W = 8;
  localparam int TAP_W = 3;
  localparam int V_TAPS = 8;
  localparam int LB_LINES = V_TAPS - 1;
  localparam int LB_MIN = 4;
  localparam int LB_MAX = 3076;
  localparam int LB_CFG_W = 12;
  localparam logic [LB_CFG_W-1:0] LB_CFG_MAX = 12'hC00;
  localparam int FIFO_DEPTH = 8;

endpackage

// ### hdl/pix_fifo.sv
/*
 * Small synchronous FIFO standing in the pixel path, valid and ready on both sides.
 * Assumes one clock and an asynchronous active-low reset; both flags are registered.
 */
`timescale 1ns/10ps
module pix_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // Draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);

  localparam int PTR_W = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wp;
    logic [PTR_W-1:0] rp;
    logic [PTR_W:0] cnt;
    logic not_full;
    logic not_empty;
  } fifo_s;

  fifo_s st_r;
  fifo_s st_nxt;
  logic push;
  logic pop;

  // Flags come straight from the state register
  assign in_ready = st_r.not_full;
  assign out_valid = st_r.not_empty;
  assign out_data = st_r.mem[st_r.rp];
  assign push = in_valid && st_r.not_full;
  assign pop = out_ready && st_r.not_empty;

  // Pointer and count update
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == PTR_W'(DEPTH - 1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == PTR_W'(DEPTH - 1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (PTR_W+1)'(push) - (PTR_W+1)'(pop);
    st_nxt.not_full = (st_nxt.cnt != (PTR_W+1)'(DEPTH));
    st_nxt.not_empty = (st_nxt.cnt != '0);
  end

  // State register
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
      st_r.not_full <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // A full FIFO refuses further words
  property p_full_refuses;
    @(posedge sys_clk) disable iff (!arst_n)
      (st_r.cnt == (PTR_W+1)'(DEPTH)) |-> !in_ready;
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("fifo full but ready");

endmodule

// ### hdl/sync_ram.sv
/*
 * Simple two-port memory with lane write enables and a registered read port.
 * Assumes writes and reads on one clock; contents are not reset.
 */
`timescale 1ns/10ps
module sync_ram #(
  parameter int WIDTH = 96,
  parameter int DEPTH = 256,
  parameter int LANES = 8,
  parameter int ADDR_W = 8
) (
  // Clock
  input wire logic sys_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [LANES-1:0] wr_lane,
  input wire logic [ADDR_W-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read port
  input wire logic [ADDR_W-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  localparam int LANE_W = WIDTH / LANES;

  logic [WIDTH-1:0] mem [DEPTH];

  // Lane-wise write leaves the other lanes and words untouched
  always_ff @(posedge sys_clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_en && wr_lane[l]) begin
        mem[wr_addr][l*LANE_W +: LANE_W] <= wr_data[l*LANE_W +: LANE_W];
      end
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ### hdl/image_filter.sv
/*
 * Two-dimensional image FIR core: horizontal preadd filter with programmable
 * interleave/decimation delay registers, vertical eight-tap filter on a packed
 * line buffer, two coefficient stores and shift-enable gating.
 * Assumes all pins except the asynchronous arst_n are synchronous to sys_clk and the controller honours pauses.
 */
`timescale 1ns/10ps
// Operation
// - Pixel path accepts and filters data at clock rates up to 111 MHz.
// - Pixels, coefficients and outputs are 12-bit two's complement values.
// - Horizontal filter gives 16 taps symmetric, 8 taps asymmetric.
// - Vertical filter is eight taps; line buffers run 4 to 3076 pixels.
// - Horizontal and vertical filters work in cascade or concurrently.
// - Store 256 sets per filter; loading one filter spares the other.
// - Rewriting one coefficient set leaves all other sets unchanged.
// - One stream of up to sixteen interleaved sets is filtered directly.
// - Each preadd sums two delayed samples feeding one shared-coefficient multiply.
// - Config 0 bit 0 selects A+B or B-A preadd.
// - Config 0 bits 1 and 2 pass operand A or B; a clear bit forces it to zero.
// - Config 1 bits 4 to 1 set delay register length.
// - Decimate by N: output once per N clocks, idle cycles add taps.
// - Separate mode: horizontal shift enable gates forward and reverse delay loading.
// - Orthogonal mode: loading needs both shift enables; either one blocks it.
// - Pass bits choose forward or reverse path operand, else zero.
module image_filter (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Pixel stream
  input wire logic [hfilt_pkg::DATA_W-1:0] pixel_input_bus,
  input wire logic pixel_valid,
  output logic pixel_ready,
  // Shift enables and modes
  input wire logic horiz_shift_enable,
  input wire logic vert_shift_enable,
  input wire logic orth_mode,
  input wire logic cascade_mode,
  input wire logic decim_en,
  // Configuration bits
  input wire logic [2:0] cfg0_bits,
  input wire logic [hfilt_pkg::ID_LEN_MSB:0] cfg1_bits,
  input wire logic [hfilt_pkg::LB_CFG_W-1:0] lb_len_cfg,
  // Coefficient set selection
  input wire logic [hfilt_pkg::SET_W-1:0] h_set_sel,
  input wire logic [hfilt_pkg::SET_W-1:0] v_set_sel,
  // Coefficient loading
  input wire logic coef_wr,
  input wire logic coef_vert,
  input wire logic [hfilt_pkg::SET_W-1:0] coef_set,
  input wire logic [hfilt_pkg::TAP_W-1:0] coef_tap,
  input wire logic [hfilt_pkg::COEF_W-1:0] coef_data,
  input wire logic load_pause,
  // Filter outputs
  output logic [hfilt_pkg::DATA_W-1:0] h_out,
  output logic h_out_valid,
  output logic [hfilt_pkg::DATA_W-1:0] v_out,
  output logic v_out_valid
);

  localparam int DW = hfilt_pkg::DATA_W;
  localparam int CW = hfilt_pkg::COEF_W;
  localparam int NA = hfilt_pkg::H_ALUS;
  localparam int LBW = hfilt_pkg::LB_LINES * DW;
  localparam int HCW = NA * CW;
  localparam int VCW = hfilt_pkg::V_TAPS * CW;

  typedef struct packed {
    logic [NA-1:0][hfilt_pkg::ID_MAX-1:0][DW-1:0] fwd;
    logic [NA-1:0][hfilt_pkg::ID_MAX-1:0][DW-1:0] rev;
    logic [DW-1:0] in_r;
    logic [NA-1:0][hfilt_pkg::PRE_W-1:0] pre;
    logic pre_v;
    logic [hfilt_pkg::ACC_W-1:0] acc;
    logic [hfilt_pkg::LEN_W-1:0] phase;
    logic [DW-1:0] hout;
    logic hout_v;
    logic [DW-1:0] vpix;
    logic [hfilt_pkg::LB_CFG_W-1:0] lb_ptr;
    logic [hfilt_pkg::LB_CFG_W-1:0] lb_wptr;
    logic lb_wr;
    logic [DW-1:0] vout;
    logic vout_v;
  } filt_s;

  filt_s st_r;
  filt_s st_nxt;
  logic [DW-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic in_gate;
  logic h_shift;
  logic v_adv;
  logic [hfilt_pkg::LEN_W-1:0] tap_sel;
  logic [hfilt_pkg::LB_CFG_W-1:0] lb_len;
  logic h_wr;
  logic v_wr;
  logic [NA-1:0] coef_lane;
  logic [HCW-1:0] h_coef;
  logic [VCW-1:0] v_coef;
  logic [LBW-1:0] lb_rd;

  // ----------------------------------------------------------------------
  // Input buffering and load gating
  // ----------------------------------------------------------------------
  pix_fifo #(
    .WIDTH(DW),
    .DEPTH(hfilt_pkg::FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .in_data(pixel_input_bus),
    .in_valid(pixel_valid),
    .in_ready(pixel_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(in_gate)
  );

  // Orthogonal mode needs both enables for any load; separate mode splits them
  assign in_gate = orth_mode ? (horiz_shift_enable && vert_shift_enable) : 1'b1;
  assign fifo_pop = fifo_valid && in_gate;
  assign h_shift = orth_mode ? (horiz_shift_enable && vert_shift_enable) : horiz_shift_enable;
  assign v_adv = orth_mode ? (horiz_shift_enable && vert_shift_enable) : vert_shift_enable;

  // Last tap is length minus one, so field 0 means sixteen; line buffer length is field, capped at 0xC00, plus four
  assign tap_sel = cfg1_bits[hfilt_pkg::ID_LEN_MSB:hfilt_pkg::ID_LEN_LSB] - 4'h1;
  assign lb_len = ((lb_len_cfg > hfilt_pkg::LB_CFG_MAX) ? hfilt_pkg::LB_CFG_MAX : lb_len_cfg) +
                  hfilt_pkg::LB_CFG_W'(hfilt_pkg::LB_MIN);

  // ----------------------------------------------------------------------
  // Coefficient stores
  // ----------------------------------------------------------------------
  // Writes wait out a pause and reach only the addressed filter, set and tap
  assign h_wr = coef_wr && !load_pause && !coef_vert;
  assign v_wr = coef_wr && !load_pause && coef_vert;
  assign coef_lane = NA'(1) << coef_tap;

  sync_ram #(
    .WIDTH(HCW),
    .DEPTH(hfilt_pkg::SETS),
    .LANES(NA),
    .ADDR_W(hfilt_pkg::SET_W)
  ) u_hcoef (
    .sys_clk(sys_clk),
    .wr_en(h_wr),
    .wr_lane(coef_lane),
    .wr_addr(coef_set),
    .wr_data({NA{coef_data}}),
    .rd_addr(h_set_sel),
    .rd_data(h_coef)
  );

  sync_ram #(
    .WIDTH(VCW),
    .DEPTH(hfilt_pkg::SETS),
    .LANES(hfilt_pkg::V_TAPS),
    .ADDR_W(hfilt_pkg::SET_W)
  ) u_vcoef (
    .sys_clk(sys_clk),
    .wr_en(v_wr),
    .wr_lane(coef_lane),
    .wr_addr(coef_set),
    .wr_data({hfilt_pkg::V_TAPS{coef_data}}),
    .rd_addr(v_set_sel),
    .rd_data(v_coef)
  );

  // Seven line buffers packed side by side in one word per pixel
  sync_ram #(
    .WIDTH(LBW),
    .DEPTH(hfilt_pkg::LB_MAX),
    .LANES(1),
    .ADDR_W(hfilt_pkg::LB_CFG_W)
  ) u_lines (
    .sys_clk(sys_clk),
    .wr_en(st_r.lb_wr),
    .wr_lane(1'b1),
    .wr_addr(st_r.lb_wptr),
    .wr_data({lb_rd[LBW-DW-1:0], st_r.vpix}),
    .rd_addr(st_r.lb_ptr),
    .rd_data(lb_rd)
  );

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  // Delay lines, preadd, multiply-accumulate, decimation and vertical FIR
  always_comb begin
    logic [DW-1:0] a_src;
    logic [DW-1:0] b_src;
    logic signed [hfilt_pkg::PRE_W-1:0] opa;
    logic signed [hfilt_pkg::PRE_W-1:0] opb;
    logic signed [hfilt_pkg::PROD_W-1:0] prod;
    logic signed [hfilt_pkg::ACC_W-1:0] hsum;
    logic signed [hfilt_pkg::ACC_W-1:0] accsum;
    logic signed [hfilt_pkg::ACC_W-1:0] vsum;
    logic [DW-1:0] vtap;
    logic [DW-1:0] vin;
    a_src = '0;
    b_src = '0;
    opa = '0;
    opb = '0;
    prod = '0;
    hsum = '0;
    accsum = '0;
    vsum = '0;
    vtap = '0;
    vin = '0;
    st_nxt = st_r;
    if (fifo_pop) begin
      st_nxt.in_r = fifo_data;
    end
    // Each stage delays by the programmed length; the reverse path starts at the far end
    if (h_shift) begin
      for (int i = 0; i < NA; i++) begin
        st_nxt.fwd[i] = {st_r.fwd[i][hfilt_pkg::ID_MAX-2:0],
                         (i == 0) ? st_r.in_r : st_r.fwd[(i == 0) ? 0 : i-1][tap_sel]};
        st_nxt.rev[i] = {st_r.rev[i][hfilt_pkg::ID_MAX-2:0],
                         (i == 0) ? st_r.fwd[NA-1][tap_sel] : st_r.rev[(i == 0) ? 0 : i-1][tap_sel]};
      end
    end
    // Preadd of the forward and mirrored reverse samples
    for (int i = 0; i < NA; i++) begin
      a_src = st_r.fwd[i][tap_sel];
      b_src = st_r.rev[NA-1-i][tap_sel];
      opa = cfg0_bits[hfilt_pkg::PASS_A_BIT] ? hfilt_pkg::PRE_W'($signed(a_src)) : '0;
      opb = cfg0_bits[hfilt_pkg::PASS_B_BIT] ? hfilt_pkg::PRE_W'($signed(b_src)) : '0;
      st_nxt.pre[i] = cfg0_bits[hfilt_pkg::ALU_MODE_BIT] ? opb - opa : opa + opb;
    end
    st_nxt.pre_v = h_shift;
    // Each preadd result meets one shared coefficient
    for (int i = 0; i < NA; i++) begin
      prod = $signed(st_r.pre[i]) * $signed(h_coef[i*CW +: CW]);
      hsum = hsum + hfilt_pkg::ACC_W'(prod);
    end
    // Decimation gathers N cycles of taps into one output
    st_nxt.hout_v = 1'b0;
    if (st_r.pre_v) begin
      accsum = ((st_r.phase == '0) ? '0 : $signed(st_r.acc)) + hsum;
      if (!decim_en || (st_r.phase == tap_sel)) begin
        st_nxt.hout = accsum[hfilt_pkg::OUT_LSB +: DW];
        st_nxt.hout_v = 1'b1;
        st_nxt.phase = '0;
        st_nxt.acc = '0;
      end else begin
        st_nxt.acc = accsum;
        st_nxt.phase = st_r.phase + 1'b1;
      end
    end
    // Vertical input comes from the pixel register or the horizontal output
    vin = cascade_mode ? st_r.hout : st_r.in_r;
    st_nxt.lb_wr = v_adv;
    if (v_adv) begin
      st_nxt.vpix = vin;
      st_nxt.lb_wptr = st_r.lb_ptr;
      st_nxt.lb_ptr = (st_r.lb_ptr >= lb_len - 1'b1) ? '0 : st_r.lb_ptr + 1'b1;
    end
    // Newest pixel plus seven delayed lines form the eight vertical taps
    for (int k = 0; k < hfilt_pkg::V_TAPS; k++) begin
      vtap = (k == 0) ? st_r.vpix : lb_rd[((k == 0) ? 0 : k-1)*DW +: DW];
      vsum = vsum + hfilt_pkg::ACC_W'($signed(vtap) * $signed(v_coef[k*CW +: CW]));
    end
    st_nxt.vout_v = st_r.lb_wr;
    if (st_r.lb_wr) begin
      st_nxt.vout = vsum[hfilt_pkg::OUT_LSB +: DW];
    end
  end

  // State register, one rising edge for the whole datapath
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from the state register
  assign h_out = st_r.hout;
  assign h_out_valid = st_r.hout_v;
  assign v_out = st_r.vout;
  assign v_out_valid = st_r.vout_v;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_line_step;
    v_adv;
  endsequence
  sequence s_line_result;
    st_r.lb_wr ##1 v_out_valid;
  endsequence
  property p_pause_hold;
    @(posedge sys_clk) disable iff (!arst_n) load_pause |-> !h_wr && !v_wr;
  endproperty
  a_pause_hold: assert property (p_pause_hold) else $error("coefficient written during pause");
  property p_coef_split;
    @(posedge sys_clk) disable iff (!arst_n) coef_wr && !load_pause |-> (h_wr != v_wr) && $onehot(coef_lane);
  endproperty
  a_coef_split: assert property (p_coef_split) else $error("coefficient write not confined");
  property p_orth_gate;
    @(posedge sys_clk) disable iff (!arst_n)
      orth_mode && !(horiz_shift_enable && vert_shift_enable) |-> !fifo_pop ##1 $stable(st_r.fwd);
  endproperty
  a_orth_gate: assert property (p_orth_gate) else $error("load in orthogonal mode without both enables");
  property p_sep_gate;
    @(posedge sys_clk) disable iff (!arst_n) !orth_mode && !horiz_shift_enable |=> $stable(st_r.rev) && !st_r.pre_v;
  endproperty
  a_sep_gate: assert property (p_sep_gate) else $error("delay registers moved without shift enable");
  property p_zero_ops;
    @(posedge sys_clk) disable iff (!arst_n) cfg0_bits[2:1] == 2'b00 |=> st_r.pre == '0;
  endproperty
  a_zero_ops: assert property (p_zero_ops) else $error("preadd not zero with both operands off");
  property p_nodecim;
    @(posedge sys_clk) disable iff (!arst_n) !decim_en && st_r.pre_v |=> h_out_valid;
  endproperty
  a_nodecim: assert property (p_nodecim) else $error("output missing without decimation");
  property p_phase_bound;
    @(posedge sys_clk) disable iff (!arst_n)
      decim_en && $stable(cfg1_bits) && h_out_valid |-> st_r.phase == '0 && st_r.phase <= tap_sel;
  endproperty
  a_phase_bound: assert property (p_phase_bound) else $error("decimation phase out of range");
  property p_lb_pipe;
    @(posedge sys_clk) disable iff (!arst_n) s_line_step |=> s_line_result;
  endproperty
  a_lb_pipe: assert property (p_lb_pipe) else $error("line buffer step lost");
  property p_lb_bound;
    @(posedge sys_clk) disable iff (!arst_n) $stable(lb_len_cfg) && !v_adv |-> ##1 st_r.lb_ptr < lb_len + 1'b1;
  endproperty
  a_lb_bound: assert property (p_lb_bound) else $error("line pointer beyond length");

endmodule

// ### tb/filter_partner.sv
/*
 * Far-side model of the filter core: a pixel source and a coefficient loader.
 * Assumes the core's clock and active-low reset; the bench steers it by ports and load_set.
 */
`timescale 1ns/10ps
module filter_partner (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  // Bench control
  input wire logic src_en,
  input wire logic [hfilt_pkg::DATA_W-1:0] src_a,
  input wire logic [hfilt_pkg::DATA_W-1:0] src_b,
  output logic [15:0] n_acc,
  // Pixel stream
  output logic [hfilt_pkg::DATA_W-1:0] pixel_input_bus,
  output logic pixel_valid,
  input wire logic pixel_ready,
  // Coefficient loading
  output logic coef_wr,
  output logic coef_vert,
  output logic [hfilt_pkg::SET_W-1:0] coef_set,
  output logic [hfilt_pkg::TAP_W-1:0] coef_tap,
  output logic [hfilt_pkg::COEF_W-1:0] coef_data,
  output logic load_pause
);
  logic sel_b_r;
  logic taken;

  // ------------------------------------------------------------------
  // Pixel source
  // ------------------------------------------------------------------
  // Offer held until taken; words alternate between the two pattern values
  always @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pixel_valid <= 1'b0;
      sel_b_r <= 1'b0;
      n_acc <= 16'h0000;
    end else begin
      if (pixel_valid && pixel_ready) begin
        sel_b_r <= ~sel_b_r;
        n_acc <= n_acc + 16'h0001;
      end
      pixel_valid <= src_en || (pixel_valid && !pixel_ready);
    end
  end

  // Idle bus shows the inverse word so stale data never looks valid
  assign pixel_input_bus = pixel_valid ? (sel_b_r ? src_b : src_a) : ~(sel_b_r ? src_b : src_a);

  // ------------------------------------------------------------------
  // Coefficient loader
  // ------------------------------------------------------------------
  initial begin
    coef_wr = 1'b0;
    coef_vert = 1'b0;
    coef_set = 8'h00;
    coef_tap = 3'h0;
    coef_data = 12'h000;
    load_pause = 1'b1;
  end

  // Eight taps of one set; every other cycle paused, write held until taken
  task automatic load_set(input logic vert, input logic [hfilt_pkg::SET_W-1:0] set, input logic [11:0] coef);
    @(posedge sys_clk);
    for (int t = 0; t < 8; t++) begin
      coef_wr <= 1'b1;
      coef_vert <= vert;
      coef_set <= set;
      coef_tap <= t[2:0];
      coef_data <= coef;
      taken = 1'b0;
      while (!taken) begin
        @(posedge sys_clk);
        taken = !load_pause;
        load_pause <= ~load_pause;
      end
    end
    coef_wr <= 1'b0;
    coef_data <= ~coef;
  endtask
endmodule

// ### tb/tb_image_filter.sv
/*
 * Self-checking bench for the image filter core: preadd modes, coefficient
 * stores, interleave, decimation, shift-enable gating and line buffers.
 * Assumes filter_partner as far side and the hfilt_pkg constants.
 */
`timescale 1ns/10ps
module tb_image_filter;
  // ------------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------------
  logic sys_clk, arst_n, pixel_valid, pixel_ready, h_out_valid, v_out_valid, src_en;
  logic [hfilt_pkg::DATA_W-1:0] pixel_input_bus, h_out, v_out, src_a, src_b, v1, v2;
  logic horiz_shift_enable, vert_shift_enable, orth_mode, cascade_mode, decim_en;
  logic [2:0] cfg0_bits;
  logic [hfilt_pkg::ID_LEN_MSB:0] cfg1_bits;
  logic [hfilt_pkg::LB_CFG_W-1:0] lb_len_cfg;
  logic [hfilt_pkg::SET_W-1:0] h_set_sel, v_set_sel, coef_set;
  logic coef_wr, coef_vert, load_pause;
  logic [hfilt_pkg::TAP_W-1:0] coef_tap;
  logic [hfilt_pkg::COEF_W-1:0] coef_data;
  logic [15:0] n_acc, cnt, base;
  int n_mismatch = 0;
  int comparisons = 0;
  // Output per config-0 value for a stream of -200 and coefficient 128
  localparam logic [11:0] PRE_EXP [8] = '{12'h000, 12'h000, 12'hF9C, 12'h064, 12'hF9C, 12'hF9C, 12'hF38, 12'h000};

  image_filter i_image_filter (.sys_clk, .arst_n, .pixel_input_bus, .pixel_valid, .pixel_ready,
    .horiz_shift_enable, .vert_shift_enable, .orth_mode, .cascade_mode, .decim_en, .cfg0_bits,
    .cfg1_bits, .lb_len_cfg, .h_set_sel, .v_set_sel, .coef_wr, .coef_vert, .coef_set, .coef_tap,
    .coef_data, .load_pause, .h_out, .h_out_valid, .v_out, .v_out_valid);
  filter_partner i_filter_partner (.sys_clk, .arst_n, .src_en, .src_a, .src_b, .n_acc,
    .pixel_input_bus, .pixel_valid, .pixel_ready, .coef_wr, .coef_vert, .coef_set, .coef_tap,
    .coef_data, .load_pause);

  // ------------------------------------------------------------------
  // Clock, watchdog and tasks
  // ------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Tests take about 30000 cycles; cut off at twice that
  initial begin
    #600000;
    n_mismatch++;
    final_report();
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cfg(input logic orth, hs, vs, dec, input logic [2:0] c0, input logic [3:0] len);
    @(posedge sys_clk);
    orth_mode <= orth;
    horiz_shift_enable <= hs;
    vert_shift_enable <= vs;
    decim_en <= dec;
    cfg0_bits <= c0;
    cfg1_bits <= {len, 1'b0};
  endtask

  task automatic vcfg(input logic [7:0] hsel, vsel, input logic casc, input logic [11:0] lb);
    @(posedge sys_clk);
    h_set_sel <= hsel;
    v_set_sel <= vsel;
    cascade_mode <= casc;
    lb_len_cfg <= lb;
  endtask

  // Source halts; pattern changes only once its offer is gone
  task automatic stop();
    @(posedge sys_clk);
    src_en <= 1'b0;
    for (int i = 0; i < 60 && pixel_valid !== 1'b0; i++) @(posedge sys_clk);
    repeat (5) @(posedge sys_clk);
  endtask

  task automatic run(input logic [11:0] a, b, input int n);
    stop();
    src_a <= a;
    src_b <= b;
    src_en <= 1'b1;
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic count_v(input int n, output logic [15:0] c);
    c = 16'h0000;
    repeat (n) begin
      @(posedge sys_clk);
      #1;
      if (h_out_valid === 1'b1) c = c + 16'h0001;
    end
  endtask

  task automatic grab(output logic [11:0] v);
    v = 12'hXXX;
    for (int i = 0; i < 40; i++) begin
      @(posedge sys_clk);
      #1;
      if (h_out_valid === 1'b1) begin
        v = h_out;
        break;
      end
    end
  endtask

  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ------------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    src_en = 1'b0;
    src_a = 12'h000;
    src_b = 12'h000;
    {horiz_shift_enable, vert_shift_enable, orth_mode, cascade_mode, decim_en} = 5'h00;
    cfg0_bits = 3'h6;
    cfg1_bits = 5'h02;
    lb_len_cfg = 12'h000;
    h_set_sel = 8'h01;
    v_set_sel = 8'h01;
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    #1;
    check(pixel_ready, 16'h0001);
    check(h_out_valid, 16'h0000);
    i_filter_partner.load_set(1'b0, 8'h01, 12'h080); // Horizontal set 1
    i_filter_partner.load_set(1'b0, 8'h02, 12'h040); // Horizontal set 2
    for (int i = 0; i < 8; i++) begin
      cfg(1'b0, 1'b1, 1'b1, 1'b0, i[2:0], 4'h1);
      run(12'hF38, 12'hF38, 200);
      check(h_out, PRE_EXP[i]); // Preadd mode
    end
    cfg(1'b0, 1'b1, 1'b1, 1'b0, 3'h6, 4'h1);
    vcfg(8'h02, 8'h01, 1'b0, 12'h000);
    run(12'hF38, 12'hF38, 100);
    check(h_out, 12'hF9C); // Set 2
    i_filter_partner.load_set(1'b1, 8'h01, 12'h100); // Vertical set 1
    i_filter_partner.load_set(1'b0, 8'h02, 12'h020); // Rewrite set 2
    run(12'hF38, 12'hF38, 100);
    check(h_out, 12'hFCE); // New set 2
    vcfg(8'h01, 8'h01, 1'b0, 12'h000);
    run(12'hF38, 12'hF38, 100);
    check(h_out, 12'hF38); // Set 1 intact
    check(v_out, 12'hF38); // Concurrent vertical
    check(v_out_valid, 16'h0001); // Each line step gives a result
    vcfg(8'h01, 8'h01, 1'b1, 12'h000);
    run(12'h064, 12'h064, 150);
    check(v_out, 12'h064); // Cascade
    cfg(1'b0, 1'b1, 1'b1, 1'b0, 3'h6, 4'h2);
    run(12'h064, 12'hF38, 200);
    grab(v1);
    grab(v2);
    check(16'((v1 === 12'h064 && v2 === 12'hF38) || (v1 === 12'hF38 && v2 === 12'h064)), 16'h0001); // Two sets
    cfg(1'b0, 1'b1, 1'b1, 1'b1, 3'h6, 4'h4);
    run(12'h064, 12'h064, 300);
    count_v(40, cnt);
    check(cnt, 16'h000A); // One per four
    check(h_out, 12'h190); // Four phases summed
    cfg(1'b0, 1'b1, 1'b1, 1'b1, 3'h6, 4'h0);
    run(12'h064, 12'h064, 600);
    count_v(64, cnt);
    check(cnt, 16'h0004); // Length 16
    check(h_out, 12'h640); // Sixteen phases
    cfg(1'b0, 1'b0, 1'b1, 1'b0, 3'h6, 4'h1);
    run(12'h064, 12'h064, 20);
    count_v(40, cnt);
    check(cnt, 16'h0000); // Shift off
    check(pixel_ready, 16'h0001); // Input still loads
    stop();
    cfg(1'b1, 1'b1, 1'b0, 1'b0, 3'h6, 4'h1);
    #1;
    base = n_acc;
    @(posedge sys_clk);
    src_en <= 1'b1;
    repeat (30) @(posedge sys_clk);
    #1;
    check(pixel_ready, 16'h0000); // Vertical blocks
    check(v_out_valid, 16'h0000); // Line buffers halted
    check(n_acc - base, 16'h0008); // FIFO full
    cfg(1'b1, 1'b0, 1'b1, 1'b0, 3'h6, 4'h1);
    src_en <= 1'b0;
    repeat (20) @(posedge sys_clk);
    #1;
    check(pixel_ready, 16'h0000); // Horizontal blocks
    cfg(1'b1, 1'b1, 1'b1, 1'b0, 3'h6, 4'h1);
    repeat (20) @(posedge sys_clk);
    #1;
    check(pixel_ready, 16'h0001); // Both on drains
    check(n_acc - base, 16'h0009); // Held word taken
    cfg(1'b0, 1'b1, 1'b1, 1'b0, 3'h6, 4'h1);
    vcfg(8'h01, 8'h01, 1'b0, 12'hC00);
    run(12'h100, 12'h100, 2000);
    check(16'(v_out !== 12'h100), 16'h0001); // Long lines not yet full
    repeat (21000) @(posedge sys_clk);
    #1;
    check(v_out, 12'h100); // 3076-pixel lines
    final_report();
  end
endmodule
